/* File: src/msfr_pkg.sv */
// Constants shared by the special function register block
// Summary of operation
// [R1] Two page bits pick one 1K program page
// [R2] Program counter loads copy page bits high
// [R3] Returns restore stack address, page bits kept
// [R4] Time-out set by sleep, clear, power up
// [R5] Power-down set by power up, clear; sleep clears
// [R6] Events give fixed time-out/power-down pairs
// [R7] Zero, aux carry, carry in bits 2..0
// [R8] Top two pointer bits pick RAM bank
// [R9] Low six bits give indirect address
// [R10] Port 5 data in bits 7..4
// [R11] Port 5 bit 0 picks control page
// [R12] Ports 6..8 hold full 8-bit data
// [R13] Bias bit picks half or third bias
// [R14] Duty field: 2, 3, else 4 commons
// [R15] Display off holds outputs at ground
// [R16] Waveform bit picks A or B type
// [R17] Frame divisor from rate and duty table
// [R18] Segment address five bits, upper read zero
// [R19] Data buffer moves four common bits
// [R20] Enable bits start timers and counters
// [R21] Software writes zero to spare enable bits
// [R22] Address 0 redirects through the pointer
// [R23] Data buffer reads/writes display RAM
package msfr_pkg;
  // Register indexes; byte address is four times these
  localparam logic [5:0] IDX_INDIRECT   = 6'h00;
  localparam logic [5:0] IDX_STATUS     = 6'h03;
  localparam logic [5:0] IDX_BANK_PTR   = 6'h04;
  localparam logic [5:0] IDX_PORT5      = 6'h05;
  localparam logic [5:0] IDX_PORT6      = 6'h06;
  localparam logic [5:0] IDX_PORT7      = 6'h07;
  localparam logic [5:0] IDX_PORT8      = 6'h08;
  localparam logic [5:0] IDX_DISP_CTRL  = 6'h09;
  localparam logic [5:0] IDX_SEG_ADDR   = 6'h0a;
  localparam logic [5:0] IDX_SEG_DATA   = 6'h0b;
  localparam logic [5:0] IDX_CNT_EN     = 6'h0c;
  // Status fields
  localparam int ST_PAGE_LO = 5;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_PWRDOWN = 3;
  localparam int ST_ZERO    = 2;
  localparam int ST_AUXC    = 1;
  localparam int ST_CARRY   = 0;
  // Display control fields
  localparam int DC_BIAS    = 7;
  localparam int DC_DUTY_LO = 5;
  localparam int DC_ON      = 4;
  localparam int DC_WAVE    = 2;
  localparam int DC_RATE_LO = 0;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_ZERO8  = 8'h00;
  localparam logic [11:0] RST_PC    = 12'h000;
  // Frame divisors, entry = rate * 3 + duty code
  localparam logic [11:0][8:0] FRAME_DIV_TAB = {
    9'h074, 9'h09c, 9'h0e8, 9'h098, 9'h0cc, 9'h130,
    9'h08c, 9'h0bc, 9'h118, 9'h080, 9'h0ac, 9'h100};
  // Program page geometry
  localparam int PAGE_LSB = 10;
endpackage

/* File: src/msfr_disp_ram.sv */
// Display RAM: one nibble of common data per segment
`timescale 1ns/1ps
`default_nettype none
module msfr_disp_ram #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int DW    = 4
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Bus side port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] bus_addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] bus_data,
  // Panel driver port
  input  wire logic [AW-1:0] drv_addr,
  output logic      [DW-1:0] drv_data
);
  logic [DW-1:0] mem_ff [DEPTH];

  // Flop storage, cleared so a fresh panel shows blank
  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst) begin
        mem_ff[i] <= '0;
      end else if (wr_en && bus_addr == AW'(i)) begin
        mem_ff[i] <= wr_data;
      end
    end
  end

  // Both reads are plain index selects
  assign bus_data = mem_ff[bus_addr];
  assign drv_data = mem_ff[drv_addr];
endmodule
`default_nettype wire

/* File: src/msfr_top.sv */
// Special function registers behind an AHB-Lite slave
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module msfr_top #(
  parameter int SEGS = 32
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Core events and flags
  input  wire logic        SLEEPING,
  input  wire logic        EV_SLEEP,
  input  wire logic        EV_WDT_CLEAR,
  input  wire logic        EV_WDT_TIMEOUT,
  input  wire logic        EV_PIN_WAKE,
  input  wire logic        FLAG_WE,
  input  wire logic [2:0]  FLAG_IN,
  // Program counter
  input  wire logic        PC_LOAD,
  input  wire logic [9:0]  PC_TARGET,
  input  wire logic        PC_RETURN,
  input  wire logic [11:0] STACK_ADDR,
  output logic      [11:0] PC_OUT,
  // Banking and control page
  output logic      [5:0]  INDIRECT_ADDR,
  output logic      [1:0]  BANK_SEL,
  output logic             CONTROL_PAGE,
  // Port pins, direction bit high means input
  input  wire logic [3:0]  P5_DIR,
  input  wire logic [3:0]  P5_IN,
  output logic      [3:0]  P5_OUT,
  output logic      [3:0]  P5_OE,
  input  wire logic [7:0]  P6_DIR,
  input  wire logic [7:0]  P6_IN,
  output logic      [7:0]  P6_OUT,
  output logic      [7:0]  P6_OE,
  input  wire logic [7:0]  P7_DIR,
  input  wire logic [7:0]  P7_IN,
  output logic      [7:0]  P7_OUT,
  output logic      [7:0]  P7_OE,
  input  wire logic [7:0]  P8_DIR,
  input  wire logic [7:0]  P8_IN,
  output logic      [7:0]  P8_OUT,
  output logic      [7:0]  P8_OE,
  // Display driver settings
  output logic             BIAS_THIRD,
  output logic      [2:0]  DUTY_COUNT,
  output logic             DISPLAY_ON,
  output logic             WAVE_B,
  output logic      [8:0]  FRAME_DIV,
  input  wire logic [4:0]  DRV_ADDR,
  output logic      [3:0]  DRV_DATA,
  // Timer and counter enables
  output logic             LPWT_EN,
  output logic             HPWT_EN,
  output logic             CNT2_EN,
  output logic             CNT1_EN
);
  logic [7:0]  status_ff, bank_ff, p5_ff, p6_ff, p7_ff, p8_ff;
  logic [7:0]  dctrl_ff, cnt_ff, nxt_status;
  logic [4:0]  seg_addr_ff;
  logic [11:0] pc_ff;
  logic [27:0] pin_meta_ff, pin_sync_ff;
  logic [5:0]  idx_ff;
  logic        wr_pend_ff, rd_pend_ff, bad_ff;
  logic [31:0] hrdata_ff;

  // Address phase decode
  wire        take    = HSEL & HTRANS[1] & HREADY;
  wire        bad_adr = |HADDR[31:8] | |HADDR[1:0];
  // Address 0 has no storage; go through the pointer
  wire [5:0]  eff_idx = (idx_ff == msfr_pkg::IDX_INDIRECT) ?
                        bank_ff[5:0] : idx_ff; // [R22]
  wire        wr_go   = wr_pend_ff & ~bad_ff;
  wire [7:0]  wd      = HWDATA[7:0];
  wire        wr_st   = wr_go & (eff_idx == msfr_pkg::IDX_STATUS);
  wire        wr_bk   = wr_go & (eff_idx == msfr_pkg::IDX_BANK_PTR);
  wire        wr_p5   = wr_go & (eff_idx == msfr_pkg::IDX_PORT5);
  wire        wr_p6   = wr_go & (eff_idx == msfr_pkg::IDX_PORT6);
  wire        wr_p7   = wr_go & (eff_idx == msfr_pkg::IDX_PORT7);
  wire        wr_p8   = wr_go & (eff_idx == msfr_pkg::IDX_PORT8);
  wire        wr_dc   = wr_go & (eff_idx == msfr_pkg::IDX_DISP_CTRL);
  wire        wr_sa   = wr_go & (eff_idx == msfr_pkg::IDX_SEG_ADDR);
  wire        wr_sd   = wr_go & (eff_idx == msfr_pkg::IDX_SEG_DATA);
  wire        wr_ce   = wr_go & (eff_idx == msfr_pkg::IDX_CNT_EN);
  wire [3:0]  ram_bus;
  wire [3:0]  ram_drv;

  // Bus transfer tracking; reads take one wait state
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      idx_ff     <= 6'h00;
      bad_ff     <= 1'b0;
    end else begin
      wr_pend_ff <= take & HWRITE;
      rd_pend_ff <= take & ~HWRITE;
      if (take) begin
        idx_ff <= HADDR[7:2];
        bad_ff <= bad_adr;
      end
    end
  end

  // Pins come from outside: two flops before use
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {P8_IN, P7_IN, P6_IN, P5_IN};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Input bits read the pin, output bits the latch
  wire [3:0] p5_rd = (P5_DIR & pin_sync_ff[3:0]) |
                     (~P5_DIR & p5_ff[7:4]); // [R10]
  wire [7:0] p6_rd = (P6_DIR & pin_sync_ff[11:4]) |
                     (~P6_DIR & p6_ff); // [R12]
  wire [7:0] p7_rd = (P7_DIR & pin_sync_ff[19:12]) |
                     (~P7_DIR & p7_ff); // [R12]
  wire [7:0] p8_rd = (P8_DIR & pin_sync_ff[27:20]) |
                     (~P8_DIR & p8_ff); // [R12]

  // Read mux; unused and reserved bits read zero
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    if (!bad_ff) begin
      case (eff_idx)
        msfr_pkg::IDX_STATUS:    rmux = status_ff;
        msfr_pkg::IDX_BANK_PTR:  rmux = bank_ff;
        msfr_pkg::IDX_PORT5:     rmux = {p5_rd, 3'h0, p5_ff[0]};
        msfr_pkg::IDX_PORT6:     rmux = p6_rd;
        msfr_pkg::IDX_PORT7:     rmux = p7_rd;
        msfr_pkg::IDX_PORT8:     rmux = p8_rd;
        msfr_pkg::IDX_DISP_CTRL: rmux = dctrl_ff;
        msfr_pkg::IDX_SEG_ADDR:  rmux = {3'h0, seg_addr_ff}; // [R18]
        msfr_pkg::IDX_SEG_DATA:  rmux = {4'h0, ram_bus}; // [R19] [R23]
        msfr_pkg::IDX_CNT_EN:    rmux = cnt_ff;
        default:                 rmux = 8'h00;
      endcase
    end
  end

  // Read data is captured in the wait cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= {24'h00_0000, rmux};
    end
  end

  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = ~rd_pend_ff;
  assign HRESP     = 1'b0;

  // Status next value: bus write, then core flags, then events
  always_comb begin
    nxt_status = status_ff;
    nxt_status[7] = 1'b0; // [R7]
    if (wr_st) begin
      nxt_status[6:5] = wd[6:5]; // [R1]
      nxt_status[2:0] = wd[2:0]; // [R7]
    end
    // Core flag update beats a software write
    if (FLAG_WE) begin
      nxt_status[2:0] = FLAG_IN; // [R7]
    end
    if (EV_PIN_WAKE) begin
      nxt_status[4:3] = 2'b10; // [R6]
    end
    if (EV_SLEEP) begin
      nxt_status[4:3] = 2'b10; // [R4] [R5]
    end
    if (EV_WDT_CLEAR) begin
      nxt_status[4:3] = 2'b11; // [R4] [R5]
    end
    // Timeout outside sleep sets power-down high
    if (EV_WDT_TIMEOUT) begin
      nxt_status[4:3] = {1'b0, ~SLEEPING}; // [R4] [R6]
    end
  end

  // Status register; reset is power up: T and P both high
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status_ff <= msfr_pkg::RST_STATUS; // [R6]
    end else begin
      status_ff <= nxt_status;
    end
  end

  wire [1:0] page = status_ff[msfr_pkg::ST_PAGE_LO +: 2];

  // Program counter: loads take the page, returns keep it
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pc_ff <= msfr_pkg::RST_PC;
    end else if (PC_RETURN) begin
      pc_ff <= STACK_ADDR; // [R3]
    end else if (PC_LOAD) begin
      pc_ff <= {page, PC_TARGET}; // [R1] [R2]
    end
  end

  assign PC_OUT = pc_ff;

  // Plain storage registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bank_ff     <= msfr_pkg::RST_ZERO8;
      p5_ff       <= msfr_pkg::RST_ZERO8;
      p6_ff       <= msfr_pkg::RST_ZERO8;
      p7_ff       <= msfr_pkg::RST_ZERO8;
      p8_ff       <= msfr_pkg::RST_ZERO8;
      dctrl_ff    <= msfr_pkg::RST_ZERO8;
      seg_addr_ff <= 5'h00;
      cnt_ff      <= msfr_pkg::RST_ZERO8;
    end else begin
      if (wr_bk) bank_ff <= wd; // [R8] [R9]
      if (wr_p5) p5_ff <= {wd[7:4], 3'h0, wd[0]}; // [R10] [R11]
      if (wr_p6) p6_ff <= wd; // [R12]
      if (wr_p7) p7_ff <= wd; // [R12]
      if (wr_p8) p8_ff <= wd; // [R12]
      if (wr_dc) dctrl_ff <= {wd[7:4], 1'b0, wd[2:0]};
      if (wr_sa) seg_addr_ff <= wd[4:0]; // [R18]
      // Spare bits are dropped; software keeps them zero
      if (wr_ce) cnt_ff <= {4'h0, wd[3:0]}; // [R20] [R21]
    end
  end

  // Banking and page outputs
  assign INDIRECT_ADDR = bank_ff[5:0]; // [R9]
  assign BANK_SEL      = bank_ff[7:6]; // [R8]
  assign CONTROL_PAGE  = p5_ff[0]; // [R11]

  // Port drivers; a direction bit of one releases the pin
  assign P5_OUT = p5_ff[7:4]; // [R10]
  assign P5_OE  = ~P5_DIR;
  assign P6_OUT = p6_ff; // [R12]
  assign P6_OE  = ~P6_DIR;
  assign P7_OUT = p7_ff;
  assign P7_OE  = ~P7_DIR;
  assign P8_OUT = p8_ff;
  assign P8_OE  = ~P8_DIR;

  // Display settings decode
  wire [1:0] duty = dctrl_ff[msfr_pkg::DC_DUTY_LO +: 2];
  wire [1:0] rate = dctrl_ff[msfr_pkg::DC_RATE_LO +: 2];
  wire [1:0] dcode = duty[1] ? 2'd2 : {1'b0, duty[0]}; // [R14]
  wire [3:0] tab_i = 4'({rate, 1'b0}) + 4'(rate) + 4'(dcode);

  assign BIAS_THIRD = dctrl_ff[msfr_pkg::DC_BIAS]; // [R13]
  assign DUTY_COUNT = 3'(dcode) + 3'd2; // [R14]
  assign DISPLAY_ON = dctrl_ff[msfr_pkg::DC_ON]; // [R15]
  assign WAVE_B     = dctrl_ff[msfr_pkg::DC_WAVE]; // [R16]
  assign FRAME_DIV  = msfr_pkg::FRAME_DIV_TAB[tab_i]; // [R17]
  // Panel sees ground while the display is off
  assign DRV_DATA   = DISPLAY_ON ? ram_drv : 4'h0; // [R15]

  // Counter enables
  assign LPWT_EN = cnt_ff[3]; // [R20]
  assign HPWT_EN = cnt_ff[2];
  assign CNT2_EN = cnt_ff[1];
  assign CNT1_EN = cnt_ff[0];

  // Display RAM, written through the data buffer
  msfr_disp_ram #(
    .DEPTH (SEGS),
    .AW    (5),
    .DW    (4)
  ) u_ram (
    .clk      (CLOCK),
    .rst      (RST),
    .wr_en    (wr_sd), // [R23]
    .bus_addr (seg_addr_ff),
    .wr_data  (wd[3:0]), // [R19]
    .bus_data (ram_bus),
    .drv_addr (DRV_ADDR),
    .drv_data (ram_drv)
  );

  // Checks
  wire ev_only_sleep = EV_SLEEP & ~EV_WDT_CLEAR & ~EV_WDT_TIMEOUT;

  property p_pc_page;
    @(posedge CLOCK) disable iff (RST)
      PC_LOAD && !PC_RETURN |=>
        PC_OUT == {$past(page), $past(PC_TARGET)};
  endproperty
  a_pc_page: assert property (p_pc_page) // [R2]
    else $error("page bits not copied into pc");

  property p_return;
    @(posedge CLOCK) disable iff (RST)
      PC_RETURN && !wr_st |=>
        PC_OUT == $past(STACK_ADDR) && $stable(page);
  endproperty
  a_return: assert property (p_return) // [R3]
    else $error("return changed page or lost address");

  property p_sleep;
    @(posedge CLOCK) disable iff (RST)
      ev_only_sleep |=> status_ff[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) // [R5]
    else $error("sleep did not give T=1 P=0");

  property p_wdt;
    @(posedge CLOCK) disable iff (RST)
      EV_WDT_TIMEOUT |=>
        status_ff[4:3] == {1'b0, !$past(SLEEPING)};
  endproperty
  a_wdt: assert property (p_wdt) // [R6]
    else $error("watchdog timeout gave wrong T P");

  property p_clear;
    @(posedge CLOCK) disable iff (RST)
      EV_WDT_CLEAR && !EV_WDT_TIMEOUT |=> status_ff[4:3] == 2'b11;
  endproperty
  a_clear: assert property (p_clear) // [R4]
    else $error("watchdog clear did not set T and P");

  property p_blank;
    @(posedge CLOCK) disable iff (RST)
      !DISPLAY_ON |-> DRV_DATA == 4'h0;
  endproperty
  a_blank: assert property (p_blank) // [R15]
    else $error("panel driven while display off");

  property p_duty;
    @(posedge CLOCK) disable iff (RST)
      duty[1] |-> DUTY_COUNT == 3'd4;
  endproperty
  a_duty: assert property (p_duty) // [R14]
    else $error("upper duty bit not four commons");

  property p_frame;
    @(posedge CLOCK) disable iff (RST)
      rate == 2'b11 && duty == 2'b01 |-> FRAME_DIV == 9'd156;
  endproperty
  a_frame: assert property (p_frame) // [R17]
    else $error("wrong frame divisor");

  property p_ptr;
    @(posedge CLOCK) disable iff (RST)
      wr_bk |=> INDIRECT_ADDR == $past(wd[5:0]) &&
                BANK_SEL == $past(wd[7:6]);
  endproperty
  a_ptr: assert property (p_ptr) // [R9]
    else $error("pointer write not seen");

  property p_cnt;
    @(posedge CLOCK) disable iff (RST)
      wr_ce |=> CNT1_EN == $past(wd[0]) && LPWT_EN == $past(wd[3]);
  endproperty
  a_cnt: assert property (p_cnt) // [R20]
    else $error("counter enable write not seen");

  property p_rd_wait;
    @(posedge CLOCK) disable iff (RST)
      take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) // [R23]
    else $error("read wait state wrong");

  c_read: cover property (@(posedge CLOCK) rd_pend_ff && !bad_ff);
  c_indir: cover property (@(posedge CLOCK) wr_go && idx_ff == 6'h00);
  c_ret: cover property (@(posedge CLOCK) PC_RETURN);
  c_seg: cover property (@(posedge CLOCK) wr_sd && DISPLAY_ON);
endmodule
`default_nettype wire

/* File: dv/msfr_tb_top.sv */
// Self-checking bench for the special function register block
`timescale 1ns/1ps
`default_nettype none
module msfr_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         hresp;
  logic        sleeping = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        flag_we = 1'b0;
  logic [2:0]  flag_in = 3'h0;
  logic        pc_load = 1'b0;
  logic        pc_ret = 1'b0;
  logic [9:0]  pc_tgt = 10'h0;
  logic [11:0] stack = 12'h0;
  wire  [11:0] pc_out;
  wire  [5:0]  ind_addr;
  wire  [1:0]  bank;
  wire         cpage;
  logic [7:0]  pdir = 8'h0;
  logic [7:0]  pin = 8'h0;
  wire  [3:0]  p5_out, p5_oe;
  wire  [7:0]  p6_out, p6_oe;
  wire  [7:0]  p7_out, p7_oe, p8_out, p8_oe;
  wire         bias, don, wave;
  wire  [2:0]  duty;
  wire  [8:0]  fdiv;
  logic [4:0]  drv_addr = 5'h0;
  wire  [3:0]  drv_data, en;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checks_done = 0;
  // Register pattern table and frame divisors
  logic [5:0]  idx[8] = '{6'h4, 6'h5, 6'h6, 6'h7, 6'h8, 6'h9, 6'ha, 6'hc};
  logic [7:0]  msk[8] = '{8'hff, 8'hf1, 8'hff, 8'hff, 8'hff, 8'hf7, 8'h1f,
                          8'h0f};
  logic [7:0]  vals[2] = '{8'hff, 8'h5a};
  int          div[4][3] = '{'{256, 172, 128}, '{280, 188, 140},
                             '{304, 204, 152}, '{232, 156, 116}};
  // Status events: {pin wake, timeout, clear, sleep}
  logic [3:0]  evm[6] = '{4'h4, 4'h2, 4'h4, 4'h8, 4'h2, 4'h1};
  logic        slp[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [1:0]  tp[6] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2};

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  msfr_top dut_u (
    .CLOCK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .SLEEPING(sleeping), .EV_SLEEP(ev[0]), .EV_WDT_CLEAR(ev[1]),
    .EV_WDT_TIMEOUT(ev[2]), .EV_PIN_WAKE(ev[3]), .FLAG_WE(flag_we),
    .FLAG_IN(flag_in), .PC_LOAD(pc_load), .PC_TARGET(pc_tgt),
    .PC_RETURN(pc_ret), .STACK_ADDR(stack), .PC_OUT(pc_out),
    .INDIRECT_ADDR(ind_addr), .BANK_SEL(bank), .CONTROL_PAGE(cpage),
    .P5_DIR(pdir[7:4]), .P5_IN(pin[7:4]), .P5_OUT(p5_out), .P5_OE(p5_oe),
    .P6_DIR(pdir), .P6_IN(pin), .P6_OUT(p6_out), .P6_OE(p6_oe),
    .P7_DIR(pdir), .P7_IN(pin), .P7_OUT(p7_out), .P7_OE(p7_oe),
    .P8_DIR(pdir), .P8_IN(pin), .P8_OUT(p8_out), .P8_OE(p8_oe),
    .BIAS_THIRD(bias), .DUTY_COUNT(duty), .DISPLAY_ON(don), .WAVE_B(wave),
    .FRAME_DIV(fdiv), .DRV_ADDR(drv_addr), .DRV_DATA(drv_data),
    .LPWT_EN(en[3]), .HPWT_EN(en[2]), .CNT2_EN(en[1]), .CNT1_EN(en[0]));

  // Compare a whole read word; upper lanes must read zero
  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Compare a value on output pins
  task automatic chk_pin(input string nm, input logic [11:0] e,
                         input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Wait for hready high at a rising edge; the watchdog bounds a hang
  task automatic wait_rdy;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask
  // One single-word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [7:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask
  // Write a register; one idle cycle lets outputs settle
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, {24'h0, i, 2'b00}, d);
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [5:0] i, input logic [7:0] e);
    xfer(1'b0, {24'h0, i, 2'b00}, 8'h00);
    chk_reg($sformatf("reg %0h", i), 32'(e), rd);
  endtask
  // One-cycle core event pulse
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 3; i <= 12; i++)
      rd_chk(6'(i), (i == 3) ? 8'h18 : 8'h00);
    chk_pin("pc", 12'h000, pc_out);
    $display("test reset done");
    drv_addr <= 5'h1f;
    wr(msfr_pkg::IDX_SEG_ADDR, 8'h1f);
    wr(msfr_pkg::IDX_SEG_DATA, 8'hfa);
    wr(msfr_pkg::IDX_SEG_ADDR, 8'h00);
    wr(msfr_pkg::IDX_SEG_DATA, 8'h05);
    chk_pin("drv off", 12'h0, 12'(drv_data));
    rd_chk(msfr_pkg::IDX_SEG_DATA, 8'h05);
    wr(msfr_pkg::IDX_SEG_ADDR, 8'hff);
    rd_chk(msfr_pkg::IDX_SEG_DATA, 8'h0a);
    wr(msfr_pkg::IDX_DISP_CTRL, 8'h10);
    chk_pin("drv on", 12'ha, 12'(drv_data));
    $display("test display ram done");
    // Spare counter-enable bits 7 and 5 always written as zero
    foreach (vals[k]) begin
      for (int j = 0; j < 8; j++) begin
        wr(idx[j], vals[k] & ((j == 7) ? 8'h5f : 8'hff));
        rd_chk(idx[j], vals[k] & msk[j]);
      end
      chk_pin("bank", 12'(vals[k][7:6]), 12'(bank));
      chk_pin("ind", 12'(vals[k][5:0]), 12'(ind_addr));
      chk_pin("cpage", 12'(vals[k][0]), 12'(cpage));
      chk_pin("p5", {4'hf, vals[k][7:4]}, 12'({p5_oe, p5_out}));
      chk_pin("p6", {4'h0, vals[k]}, 12'(p6_out));
      chk_pin("p7", {4'h0, vals[k]}, 12'(p7_out));
      chk_pin("p8", {4'h0, vals[k]}, 12'(p8_out));
      chk_pin("en", 12'(vals[k][3:0]), 12'(en));
      chk_pin("lcd", 12'({vals[k][7], vals[k][4], vals[k][2]}),
              12'({bias, don, wave}));
    end
    $display("test patterns done");
    for (int r = 0; r < 4; r++)
      for (int d = 0; d < 4; d++) begin
        wr(msfr_pkg::IDX_DISP_CTRL, 8'(d * 32 + 16 + r));
        chk_pin("duty", 12'((d < 2) ? d + 2 : 4), 12'(duty));
        chk_pin("fdiv", 12'(div[r][(d < 2) ? d : 2]), 12'(fdiv));
      end
    $display("test frame done");
    for (int k = 0; k < 6; k++) begin
      sleeping <= slp[k];
      pulse(evm[k]);
      rd_chk(msfr_pkg::IDX_STATUS, {3'h0, tp[k], 3'h0});
    end
    wr(msfr_pkg::IDX_STATUS, 8'h7f);
    rd_chk(msfr_pkg::IDX_STATUS, 8'h77);
    flag_in <= 3'h2;
    flag_we <= 1'b1;
    @(posedge clk);
    flag_we <= 1'b0;
    @(posedge clk);
    rd_chk(msfr_pkg::IDX_STATUS, 8'h72);
    $display("test status done");
    wr(msfr_pkg::IDX_STATUS, 8'h40);
    pc_tgt  <= 10'h155;
    pc_load <= 1'b1;
    @(posedge clk);
    pc_load <= 1'b0;
    @(posedge clk);
    chk_pin("pc load", 12'h955, pc_out);
    stack  <= 12'h3ab;
    pc_ret <= 1'b1;
    @(posedge clk);
    pc_ret <= 1'b0;
    @(posedge clk);
    chk_pin("pc ret", 12'h3ab, pc_out);
    rd_chk(msfr_pkg::IDX_STATUS, 8'h50);
    $display("test program counter done");
    wr(msfr_pkg::IDX_BANK_PTR, 8'h07);
    wr(msfr_pkg::IDX_INDIRECT, 8'h81);
    rd_chk(msfr_pkg::IDX_PORT7, 8'h81);
    rd_chk(msfr_pkg::IDX_INDIRECT, 8'h81);
    $display("test indirect done");
    // Pins released; two-flop sync needs a few cycles
    pdir <= 8'hff;
    pin  <= 8'h3c;
    repeat (4) @(posedge clk);
    rd_chk(msfr_pkg::IDX_PORT5, 8'h30);
    for (int i = 6; i <= 8; i++)
      rd_chk(6'(i), 8'h3c);
    chk_pin("p678 oe", 12'h0, 12'(p6_oe | p7_oe | p8_oe));
    $display("test port input done");
    xfer(1'b1, 32'h100, 8'h55);
    xfer(1'b0, 32'h100, 8'h00);
    chk_reg("unmapped", 32'h0000_0000, rd);
    chk_pin("hresp", 12'h0, 12'(hresp));
    $display("test unmapped done");
    final_report();
  end

  // Watchdog; the sequence needs well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH watchdog exp done got timeout");
    final_report();
  end
endmodule
`default_nettype wire
